// ---- include/adc_pkg.sv ----
// ==========================================================================
// shared constants for the link diagnostic counter bank
// ==========================================================================
package adc_pkg;

  // ========================================================================
  // counter register indices (byte address is four times the index)
  // ========================================================================
  localparam logic [7:0] IDX_SEND_ATTEMPT = 8'h15;
  localparam logic [7:0] IDX_SENT_ACKED = 8'h17;
  localparam logic [7:0] IDX_ACK_RECEIVED = 8'h19;
  localparam logic [7:0] IDX_ACK_FORWARDED = 8'h1b;
  localparam logic [7:0] IDX_NAK_RECEIVED = 8'h1c;
  localparam logic [7:0] IDX_NAK_FORWARDED = 8'h1d;
  localparam logic [7:0] IDX_RESPONSE_TIMEOUT = 8'h1e;
  localparam logic [7:0] IDX_ENQUIRY_SENT = 8'h1f;
  localparam logic [7:0] IDX_SEND_FAILED = 8'h20;
  localparam logic [7:0] IDX_REPLY_DROPPED = 8'h21;
  localparam logic [7:0] IDX_MESSAGE_RECEIVED = 8'h22;
  localparam logic [7:0] IDX_ACK_SENT = 8'h24;
  localparam logic [7:0] IDX_NAK_SENT = 8'h26;
  localparam logic [7:0] IDX_ENQUIRY_RECEIVED = 8'h27;
  localparam logic [7:0] IDX_RETRANSMISSION = 8'h28;
  localparam logic [7:0] IDX_MESSAGE_START = 8'h29;
  localparam logic [7:0] IDX_IGNORED_INPUT = 8'h2a;
  localparam logic [7:0] IDX_ENQUIRY_ABORT = 8'h2b;
  localparam logic [7:0] IDX_CONTROL_CODE_ABORT = 8'h2c;
  localparam logic [7:0] IDX_ACK_WITHOUT_BUFFER = 8'h2d;
  localparam logic [7:0] IDX_NAK_NO_BUFFER = 8'h2e;
  localparam logic [7:0] IDX_BROADCAST_RECEIVED = 8'h2f;
  localparam logic [7:0] IDX_BROADCAST_OK = 8'h30;
  localparam logic [7:0] IDX_FOREIGN_MESSAGE = 8'h31;
  localparam logic [7:0] IDX_EOT_SENT = 8'h32;
  localparam logic [7:0] IDX_CALL_RECEIVED = 8'h33;
  localparam logic [7:0] IDX_LOCAL_HANGUP = 8'h34;
  localparam logic [7:0] IDX_CARRIER_LOST = 8'h35;
  localparam logic [7:0] IDX_CARRIER_TIMEOUT_HANGUP = 8'h36;
  // control, status and station registers
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_STATION = 8'h02;

  // number of counters, in register table order
  localparam int NUM_CNT = 29;
  localparam logic [7:0] CNT_IDX [NUM_CNT] = '{
    IDX_SEND_ATTEMPT, IDX_SENT_ACKED, IDX_ACK_RECEIVED, IDX_ACK_FORWARDED,
    IDX_NAK_RECEIVED, IDX_NAK_FORWARDED, IDX_RESPONSE_TIMEOUT, IDX_ENQUIRY_SENT,
    IDX_SEND_FAILED, IDX_REPLY_DROPPED, IDX_MESSAGE_RECEIVED, IDX_ACK_SENT,
    IDX_NAK_SENT, IDX_ENQUIRY_RECEIVED, IDX_RETRANSMISSION, IDX_MESSAGE_START,
    IDX_IGNORED_INPUT, IDX_ENQUIRY_ABORT, IDX_CONTROL_CODE_ABORT,
    IDX_ACK_WITHOUT_BUFFER, IDX_NAK_NO_BUFFER, IDX_BROADCAST_RECEIVED,
    IDX_BROADCAST_OK, IDX_FOREIGN_MESSAGE, IDX_EOT_SENT, IDX_CALL_RECEIVED,
    IDX_LOCAL_HANGUP, IDX_CARRIER_LOST, IDX_CARRIER_TIMEOUT_HANGUP};
  // one bit per counter: set where the counter is 16 bits wide
  localparam logic [NUM_CNT-1:0] CNT_WIDE = 29'h0000c07;
  localparam int WIDE_W = 16;
  localparam int NARROW_W = 8;

  // ========================================================================
  // control register fields and reset values
  // ========================================================================
  localparam int CTRL_HALF_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_HALF_RST = 1'b0;
  localparam logic [7:0] STATION_RST = 8'h00;
  localparam logic [7:0] BCAST_ADDR = 8'hff;

  // ========================================================================
  // link control codes, as the character after a DLE
  // ========================================================================
  localparam logic [7:0] CODE_SOH = 8'h01;
  localparam logic [7:0] CODE_STX = 8'h02;
  localparam logic [7:0] CODE_ETX = 8'h03;
  localparam logic [7:0] CODE_ENQ = 8'h05;
  localparam logic [7:0] CODE_ACK = 8'h06;
  localparam logic [7:0] CODE_NAK = 8'h15;

  // receive framing state, one-hot
  typedef enum logic [1:0] {
    ADC_RX_IDLE = 2'b01,
    ADC_RX_MSG = 2'b10
  } adc_rx_state_t;

  // message start code depends on the duplex mode
  function automatic logic is_start_code(input logic [7:0] code, input logic half);
    is_start_code = half ? (code == CODE_SOH) : (code == CODE_STX);
  endfunction : is_start_code

  // width of counter number i
  function automatic int cnt_width(input int i);
    cnt_width = CNT_WIDE[i] ? WIDE_W : NARROW_W;
  endfunction : cnt_width

endpackage : adc_pkg

// ---- verilog/adc_sat_cnt.sv ----
`timescale 1ns/1ps
// ==========================================================================
// saturating event counter
// ==========================================================================
module adc_sat_cnt #(
  parameter int WIDTH = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] cnt
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } adc_cnt_st_t;

  localparam logic [WIDTH-1:0] CNT_MAX = '1;
  localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

  adc_cnt_st_t st_r;
  adc_cnt_st_t st_nxt;

  // next value: a clear still keeps an event of the same cycle
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.cnt = inc ? CNT_ONE : '0;
    end else if (inc && st_r.cnt != CNT_MAX) begin
      st_nxt.cnt = st_r.cnt + CNT_ONE; // stop at the top
    end
  end

  // state register, cleared at reset
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt = st_r.cnt;

  a_cnt_saturate: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_r.cnt == CNT_MAX && inc && !clr) |=> (cnt == CNT_MAX))
    else $error("counter wrapped past its maximum");

  a_cnt_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (clr && !inc) |=> (cnt == '0))
    else $error("counter not cleared");

endmodule : adc_sat_cnt

// ---- verilog/adc_retx_det.sv ----
`timescale 1ns/1ps
// ==========================================================================
// retransmission detector: remembers the last message header
// ==========================================================================
module adc_retx_det (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic sample,
  input wire logic [15:0] tns,
  input wire logic [7:0] cmd,
  input wire logic [7:0] src,
  output logic match
);

  typedef struct packed {
    logic valid;
    logic [15:0] tns;
    logic [7:0] cmd;
    logic [7:0] src;
  } adc_retx_st_t;

  adc_retx_st_t st_r;
  adc_retx_st_t st_nxt;

  // compare against the previous header; nothing matches before a first message
  assign match = st_r.valid && st_r.tns == tns && st_r.cmd == cmd && st_r.src == src;

  // store the header of every good message
  always_comb begin
    st_nxt = st_r;
    if (sample) begin
      st_nxt.valid = 1'b1;
      st_nxt.tns = tns;
      st_nxt.cmd = cmd;
      st_nxt.src = src;
    end
  end

  // state register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : adc_retx_det

// ---- verilog/adc_diag_counters.sv ----
`timescale 1ns/1ps
// Overview of operation
// - 16-bit send attempt count at 21
// - 16-bit sent-and-acknowledged count at 23
// - 16-bit received acknowledgement count at 25
// - separator ACKs at 27, NAKs at 29
// - NAKs received at 28, sent at 38
// - response timeouts at 30, enquiries sent 31
// - failed sends 32, dropped replies 33
// - messages received 34, ACKs sent 36
// - enquiries received counted at 39
// - matching header with a buffer free means retransmission: ACK, count 40
// - STX or SOH per mode counted 41
// - ignored input counted at 42
// - DLE ENQ aborts message, counted 43
// - other control code aborts, counted 44
// - ACK sent without buffer counted 45
// - no buffer gives NAK, counted 46
// - broadcasts at 47, good broadcasts 48
// - messages for other stations at 49
// - DLE EOT sent counted at 50
// - calls in 51, own hang-ups 52
// - carrier loss 53, carrier timeout hang-ups 54
module adc_diag_counters (
  input wire logic REF_CLK,
  input wire logic RST_B,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // receive side: link control codes and data characters
  input wire logic RX_CTRL_V,
  input wire logic [7:0] RX_CTRL_CODE,
  input wire logic RX_DATA_V,
  input wire logic RX_FRAME_BAD,
  input wire logic [7:0] RX_DST,
  input wire logic [7:0] RX_SRC,
  input wire logic [7:0] RX_CMD,
  input wire logic [15:0] RX_TNS,
  input wire logic BUF_AVAIL,
  // transmit side and modem events, one-cycle pulses
  input wire logic TX_ATTEMPT,
  input wire logic TX_ACKED,
  input wire logic SEP_ACK,
  input wire logic SEP_NAK,
  input wire logic RESP_TIMEOUT,
  input wire logic TX_ENQ,
  input wire logic TX_FAIL,
  input wire logic REPLY_DROP,
  input wire logic TX_ACK_SENT,
  input wire logic TX_NAK_SENT,
  input wire logic TX_EOT,
  input wire logic CALL_IN,
  input wire logic HANGUP_LOCAL,
  input wire logic DCD_LOST,
  input wire logic DCD_TO_HANGUP,
  // answers to the transmitter
  output logic SEND_ACK_REQ,
  output logic SEND_NAK_REQ,
  output logic RX_ABORT,
  output logic RX_RETX,
  output logic RX_BUSY
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    adc_pkg::adc_rx_state_t rx_state; // framing state of the receiver
    logic wb_ack; // bus answer
    logic [31:0] wb_dat; // registered read data
    logic half; // half-duplex mode selects SOH as start code
    logic clr; // one-cycle clear of every counter
    logic [7:0] station; // our own station address
    logic ack_req; // ask the transmitter for DLE ACK
    logic nak_req; // ask the transmitter for DLE NAK
    logic abort; // message in progress was abandoned
    logic retx; // last message was a retransmission
  } adc_main_st_t;

  adc_main_st_t st_r;
  adc_main_st_t st_nxt;

  logic [adc_pkg::NUM_CNT-1:0] evt; // one increment strobe per counter
  logic [15:0] cnt [adc_pkg::NUM_CNT]; // counter values, zero-extended
  logic [31:0] rd_word; // read data for the current address
  logic retx_match; // header equals the previous message
  logic in_msg; // a message is being received
  logic msg_end; // DLE ETX closes a message
  logic msg_good; // closed message passed its checks
  logic is_bcast; // message goes to every station
  logic [7:0] bus_idx; // word index on the bus

  assign in_msg = (st_r.rx_state == adc_pkg::ADC_RX_MSG);
  assign msg_end = RX_CTRL_V && in_msg && (RX_CTRL_CODE == adc_pkg::CODE_ETX);
  assign msg_good = msg_end && !RX_FRAME_BAD;
  assign is_bcast = (RX_DST == adc_pkg::BCAST_ADDR);
  assign bus_idx = {2'b00, WB_ADR_I[7:2]};

  // ========================================================================
  // counter bank
  // ========================================================================
  generate
    for (genvar i = 0; i < adc_pkg::NUM_CNT; i++) begin : g_cnt
      if (adc_pkg::cnt_width(i) == adc_pkg::WIDE_W) begin : g_wide
        adc_sat_cnt #(.WIDTH(adc_pkg::WIDE_W)) u_cnt (
          .REF_CLK(REF_CLK),
          .RST_B(RST_B),
          .inc(evt[i]),
          .clr(st_r.clr),
          .cnt(cnt[i])
        );
      end else begin : g_narrow
        // high byte of a narrow counter reads as zero
        assign cnt[i][15:8] = 8'h00;
        adc_sat_cnt #(.WIDTH(adc_pkg::NARROW_W)) u_cnt (
          .REF_CLK(REF_CLK),
          .RST_B(RST_B),
          .inc(evt[i]),
          .clr(st_r.clr),
          .cnt(cnt[i][7:0])
        );
      end
    end
  endgenerate

  // previous message header, for duplicate detection
  adc_retx_det u_retx (
    .REF_CLK(REF_CLK),
    .RST_B(RST_B),
    .sample(msg_good),
    .tns(RX_TNS),
    .cmd(RX_CMD),
    .src(RX_SRC),
    .match(retx_match)
  );

  // ========================================================================
  // read decode
  // ========================================================================
  // unmapped words, and the byte after each 16-bit counter, read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < adc_pkg::NUM_CNT; i++) begin
      if (bus_idx == adc_pkg::CNT_IDX[i]) begin
        rd_word = {16'h0000, cnt[i]};
      end
    end
    if (bus_idx == adc_pkg::IDX_CTRL) begin
      rd_word[adc_pkg::CTRL_HALF_BIT] = st_r.half;
    end
    if (bus_idx == adc_pkg::IDX_STATUS) begin
      rd_word[1:0] = {BUF_AVAIL, in_msg};
    end
    if (bus_idx == adc_pkg::IDX_STATION) begin
      rd_word[7:0] = st_r.station;
    end
  end

  // ========================================================================
  // event strobes
  // ========================================================================
  // each strobe is raised in the cycle of its cause; the counter moves at the next edge
  always_comb begin
    evt = '0;
    evt[0] = TX_ATTEMPT;
    evt[1] = TX_ACKED;
    evt[2] = RX_CTRL_V && RX_CTRL_CODE == adc_pkg::CODE_ACK;
    evt[3] = SEP_ACK;
    evt[4] = RX_CTRL_V && RX_CTRL_CODE == adc_pkg::CODE_NAK;
    evt[5] = SEP_NAK;
    evt[6] = RESP_TIMEOUT;
    evt[7] = TX_ENQ;
    evt[8] = TX_FAIL;
    evt[9] = REPLY_DROP;
    evt[10] = msg_good;
    evt[11] = TX_ACK_SENT;
    evt[12] = TX_NAK_SENT;
    evt[13] = RX_CTRL_V && RX_CTRL_CODE == adc_pkg::CODE_ENQ;
    evt[14] = msg_good && retx_match && BUF_AVAIL;
    evt[15] = RX_CTRL_V && adc_pkg::is_start_code(RX_CTRL_CODE, st_r.half);
    // stray data outside a frame, a bad frame, or a stray code while idle
    evt[16] = (RX_DATA_V && !in_msg) || (msg_end && RX_FRAME_BAD) ||
              (RX_CTRL_V && !in_msg && !evt[2] && !evt[4] && !evt[13] && !evt[15]);
    evt[17] = RX_CTRL_V && in_msg && RX_CTRL_CODE == adc_pkg::CODE_ENQ;
    evt[18] = RX_CTRL_V && in_msg && !msg_end && !evt[17];
    evt[19] = TX_ACK_SENT && !BUF_AVAIL;
    evt[20] = msg_good && !BUF_AVAIL;
    evt[21] = msg_end && is_bcast;
    evt[22] = msg_good && is_bcast;
    evt[23] = msg_end && !is_bcast && RX_DST != st_r.station;
    evt[24] = TX_EOT;
    evt[25] = CALL_IN;
    evt[26] = HANGUP_LOCAL;
    evt[27] = DCD_LOST;
    evt[28] = DCD_TO_HANGUP;
  end

  // ========================================================================
  // bus slave, receive framing and answers
  // ========================================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.wb_ack = 1'b0;
    st_nxt.clr = 1'b0;
    st_nxt.ack_req = 1'b0;
    st_nxt.nak_req = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.retx = 1'b0;
    // answer one cycle after the request, then drop ack for a cycle
    if (WB_CYC_I && WB_STB_I && !st_r.wb_ack) begin
      st_nxt.wb_ack = 1'b1;
      st_nxt.wb_dat = rd_word;
      if (WB_WE_I && WB_SEL_I[0]) begin
        // writes to counters and to unmapped words are dropped
        if (bus_idx == adc_pkg::IDX_CTRL) begin
          st_nxt.half = WB_DAT_I[adc_pkg::CTRL_HALF_BIT];
          st_nxt.clr = WB_DAT_I[adc_pkg::CTRL_CLR_BIT];
        end
        if (bus_idx == adc_pkg::IDX_STATION) begin
          st_nxt.station = WB_DAT_I[7:0];
        end
      end
    end
    // receive framing
    case (st_r.rx_state)
      adc_pkg::ADC_RX_IDLE: begin
        if (evt[15]) begin
          st_nxt.rx_state = adc_pkg::ADC_RX_MSG;
        end
      end
      adc_pkg::ADC_RX_MSG: begin
        if (evt[17]) begin
          // enquiry mid-message: drop what was gathered
          st_nxt.rx_state = adc_pkg::ADC_RX_IDLE;
          st_nxt.abort = 1'b1;
        end else if (evt[18]) begin
          // a fresh start code reopens a frame; anything else leaves it
          st_nxt.rx_state = evt[15] ? adc_pkg::ADC_RX_MSG : adc_pkg::ADC_RX_IDLE;
          st_nxt.abort = 1'b1;
        end else if (msg_end) begin
          st_nxt.rx_state = adc_pkg::ADC_RX_IDLE;
          if (RX_FRAME_BAD) begin
            st_nxt.nak_req = 1'b1;
          end else if (!BUF_AVAIL) begin
            st_nxt.nak_req = 1'b1; // refuse for lack of buffer
          end else begin
            // duplicates are acknowledged but not delivered again
            st_nxt.ack_req = 1'b1;
            st_nxt.retx = retx_match;
          end
        end
      end
      default: begin
        st_nxt.rx_state = adc_pkg::ADC_RX_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '{rx_state: adc_pkg::ADC_RX_IDLE, wb_ack: 1'b0, wb_dat: 32'h0000_0000,
                half: adc_pkg::CTRL_HALF_RST, clr: 1'b0, station: adc_pkg::STATION_RST,
                ack_req: 1'b0, nak_req: 1'b0, abort: 1'b0, retx: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign WB_ACK_O = st_r.wb_ack;
  assign WB_DAT_O = st_r.wb_dat;
  assign SEND_ACK_REQ = st_r.ack_req;
  assign SEND_NAK_REQ = st_r.nak_req;
  assign RX_ABORT = st_r.abort;
  assign RX_RETX = st_r.retx;
  assign RX_BUSY = in_msg;

  // ========================================================================
  // checks
  // ========================================================================
  sequence s_enq_in_msg;
    RX_CTRL_V && in_msg && RX_CTRL_CODE == adc_pkg::CODE_ENQ;
  endsequence

  sequence s_good_end_nobuf;
    msg_good && !BUF_AVAIL;
  endsequence

  a_attempt_count: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (TX_ATTEMPT && !st_r.clr && cnt[0] != 16'hffff) |=> (cnt[0] == $past(cnt[0]) + 16'h0001))
    else $error("send attempt count did not advance");

  a_enq_abort: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_enq_in_msg |=> (RX_ABORT && !RX_BUSY) ##1 !RX_ABORT)
    else $error("enquiry did not abandon the message");

  a_ctrl_abort: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (RX_CTRL_V && in_msg && RX_CTRL_CODE == adc_pkg::CODE_ACK) |=> RX_ABORT && !RX_BUSY)
    else $error("stray control code did not abandon the message");

  a_nobuf_nak: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_good_end_nobuf |=> SEND_NAK_REQ && !SEND_ACK_REQ)
    else $error("no buffer but no refusal");

  a_retx_ack: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (msg_good && BUF_AVAIL && retx_match) |=> SEND_ACK_REQ && RX_RETX)
    else $error("retransmission not acknowledged");

  a_start_busy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (RX_CTRL_V && !in_msg && adc_pkg::is_start_code(RX_CTRL_CODE, st_r.half)) |=> RX_BUSY)
    else $error("start code did not open a message");

  a_foreign_count: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (msg_end && RX_DST != st_r.station && !is_bcast && !st_r.clr && cnt[23] != 16'h00ff)
    |=> (cnt[23] == $past(cnt[23]) + 16'h0001))
    else $error("foreign message not counted");

  a_eot_count: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (TX_EOT && !st_r.clr && cnt[24] != 16'h00ff) |=> (cnt[24] != $past(cnt[24])))
    else $error("end of transmission not counted");

  a_wb_answer: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer not one cycle after request");

endmodule : adc_diag_counters

// ---- verification/adc_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// link partner: sends dle codes and data characters
// ==========================================================================
module adc_host_model (
  input wire logic clk,
  output logic ctrl_v,
  output logic [7:0] ctrl_code,
  output logic data_v
);
  // idle link: strobes low
  initial begin
    ctrl_v = 1'b0;
    data_v = 1'b0;
    ctrl_code = 8'h00;
  end
  // one code for one cycle; the code bus then shows a stale-looking inverse
  task automatic code(input logic [7:0] c);
    ctrl_v <= 1'b1;
    ctrl_code <= c;
    @(posedge clk);
    ctrl_v <= 1'b0;
    ctrl_code <= ~c;
    @(posedge clk);
  endtask : code
  // one plain data character
  task automatic data();
    data_v <= 1'b1;
    @(posedge clk);
    data_v <= 1'b0;
    @(posedge clk);
  endtask : data
endmodule : adc_host_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
// ==========================================================================
// bench: bus reads of counters after link and event traffic
// ==========================================================================
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic ack, cv, dv, ackq, nakq, abrt, retx, busy;
  logic bufa = 1'b1;
  logic bad = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [7:0] src = 8'h11;
  logic [7:0] cmd = 8'h22;
  logic [7:0] cc;
  logic [7:0] dst = 8'h00;
  logic [15:0] tns = 16'h0;
  logic [14:0] ev = 15'h0;
  int bad_count = 0;
  int checks_done = 0;
  // counter behind each event pulse bit
  localparam logic [7:0] EV_IDX [15] = '{8'h15, 8'h17, 8'h1b, 8'h1d, 8'h1e, 8'h1f, 8'h20,
    8'h21, 8'h24, 8'h26, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
  always #2.5 clk = ~clk;
  adc_host_model u_host (.clk(clk), .ctrl_v(cv), .ctrl_code(cc), .data_v(dv));
  adc_diag_counters u_adc_diag_counters (
    .REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .RX_CTRL_V(cv), .RX_CTRL_CODE(cc), .RX_DATA_V(dv), .RX_FRAME_BAD(bad),
    .RX_DST(dst), .RX_SRC(src), .RX_CMD(cmd), .RX_TNS(tns), .BUF_AVAIL(bufa),
    .TX_ATTEMPT(ev[0]), .TX_ACKED(ev[1]), .SEP_ACK(ev[2]), .SEP_NAK(ev[3]),
    .RESP_TIMEOUT(ev[4]), .TX_ENQ(ev[5]), .TX_FAIL(ev[6]), .REPLY_DROP(ev[7]),
    .TX_ACK_SENT(ev[8]), .TX_NAK_SENT(ev[9]), .TX_EOT(ev[10]), .CALL_IN(ev[11]),
    .HANGUP_LOCAL(ev[12]), .DCD_LOST(ev[13]), .DCD_TO_HANGUP(ev[14]),
    .SEND_ACK_REQ(ackq), .SEND_NAK_REQ(nakq), .RX_ABORT(abrt), .RX_RETX(retx),
    .RX_BUSY(busy));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // verdict, then end of run
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // classic cycle, entered just after an edge; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
    @(posedge clk);
  endtask : wb
  // read word index i and compare
  task automatic rc(input string nm, input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, {i[5:0], 2'b00}, 32'h0, q);
    chk(nm, q, e);
  endtask : rc
  // one framed message; answers looked at in the cycle after the closing code
  task automatic msg(input logic s, input logic [7:0] d, input logic [15:0] t,
    input logic b, input logic [2:0] e);
    dst <= d;
    tns <= t;
    bufa <= b;
    u_host.code(s ? 8'h01 : 8'h02);
    u_host.data();
    // the answers stand only in the cycle after the closing code's edge
    fork
      u_host.code(8'h03);
      begin
        @(posedge clk);
        #1 chk("answer", {ackq, nakq, retx}, e);
      end
    join
    @(posedge clk);
    bufa <= 1'b1;
  endtask : msg
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < adc_pkg::NUM_CNT; i++) begin
      rc("reset", adc_pkg::CNT_IDX[i], 32'h0);
    end
    rc("high byte", 8'h16, 32'h0);
    rc("unmapped", 8'h3f, 32'h0);
    // event i pulses for i+1 cycles, so crossed wires show
    for (int i = 0; i < 15; i++) begin
      ev[i] <= 1'b1;
      repeat (i + 1) @(posedge clk);
      ev[i] <= 1'b0;
    end
    for (int i = 0; i < 15; i++) begin
      rc("event", EV_IDX[i], 32'(i + 1));
    end
    wb(1'b1, 8'h54, 32'hffff, q);
    rc("read only", 8'h15, 32'h1);
    bufa <= 1'b0;
    ev[8] <= 1'b1;
    @(posedge clk);
    ev[8] <= 1'b0;
    bufa <= 1'b1;
    rc("ack no buffer", 8'h2d, 32'h1);
    u_host.data();
    rc("ignored", 8'h2a, 32'h1);
    msg(1'b0, 8'h00, 16'h3, 1'b1, 3'b100);
    rc("received", 8'h22, 32'h1);
    msg(1'b0, 8'h00, 16'h3, 1'b1, 3'b101);
    cmd <= 8'h23;
    msg(1'b0, 8'h00, 16'h3, 1'b1, 3'b100);
    src <= 8'h12;
    msg(1'b0, 8'h00, 16'h3, 1'b1, 3'b100);
    msg(1'b0, 8'h00, 16'h4, 1'b0, 3'b010);
    msg(1'b0, 8'hff, 16'h5, 1'b1, 3'b100);
    msg(1'b0, 8'h55, 16'h6, 1'b1, 3'b100);
    bad <= 1'b1;
    msg(1'b0, 8'h00, 16'h7, 1'b1, 3'b010);
    bad <= 1'b0;
    rc("retx", 8'h28, 32'h1);
    rc("no buffer", 8'h2e, 32'h1);
    rc("bcast", 8'h2f, 32'h1);
    rc("bcast ok", 8'h30, 32'h1);
    rc("foreign", 8'h31, 32'h1);
    rc("bad frame", 8'h2a, 32'h2);
    u_host.code(8'h02);
    chk("busy", 32'(busy), 32'h1);
    u_host.code(8'h05);
    rc("enq abort", 8'h2b, 32'h1);
    u_host.code(8'h02);
    u_host.code(8'h06);
    u_host.code(8'h02);
    u_host.code(8'h02);
    u_host.code(8'h03);
    rc("code abort", 8'h2c, 32'h2);
    sel <= 4'h0;
    wb(1'b1, 8'h00, 32'h1, q);
    sel <= 4'hf;
    rc("lane", 8'h00, 32'h0);
    wb(1'b1, 8'h00, 32'h1, q);
    rc("half", 8'h00, 32'h1);
    msg(1'b1, 8'h00, 16'h8, 1'b1, 3'b100);
    rc("starts", 8'h29, 32'hd);
    u_host.code(8'h06);
    u_host.code(8'h15);
    u_host.code(8'h05);
    rc("ack in", 8'h19, 32'h2);
    rc("nak in", 8'h1c, 32'h1);
    rc("enq in", 8'h27, 32'h2);
    ev[11] <= 1'b1;
    repeat (300) @(posedge clk);
    ev[11] <= 1'b0;
    rc("saturate", 8'h33, 32'hff);
    wb(1'b1, 8'h00, 32'h2, q);
    rc("cleared", 8'h33, 32'h0);
    rc("cleared", 8'h15, 32'h0);
    wrap_up();
  end
endmodule : testbench
